// File: include/ssr_pkg.sv
// ============================================================
// supply supervisor reset control: shared constants
// ============================================================
package ssr_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00; // detector control
  localparam logic [7:0] OFF_STATUS = 8'h04; // level status, read only
  localparam logic [7:0] OFF_IRQ    = 8'h08; // sticky events, w1c
  localparam logic [7:0] OFF_MASK   = 8'h0C; // interrupt mask
  localparam logic [7:0] OFF_OPT    = 8'h10; // loaded option setting
  // control field positions
  localparam int CTRL_EN_BIT   = 0;          // detector enable
  localparam int CTRL_FALL_BIT = 1;          // interrupt on fall
  localparam int CTRL_RISE_BIT = 2;          // interrupt on rise
  localparam int CTRL_LVL_LSB  = 4;          // threshold select lsb
  localparam int LVL_W         = 3;          // threshold select width
  // event bits
  localparam int EV_FALL_BIT = 0;
  localparam int EV_RISE_BIT = 1;
  localparam int EV_W        = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [EV_W-1:0] MASK_RST = 2'h0;
  // brownout option encodings
  localparam logic [1:0] BOR_OFF = 2'h0;     // brownout disabled
  localparam logic [1:0] BOR_L1  = 2'h1;
  localparam logic [1:0] BOR_L2  = 2'h2;
  localparam logic [1:0] BOR_L3  = 2'h3;
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int LOAD_NS        = 400;       // option load time
  localparam int LOAD_CYC       = (LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int REL_NS         = 80;        // reset release hold
  localparam int REL_CYC        = (REL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 8;
  // sequencer states
  typedef enum logic [3:0] {
    ST_POR  = 4'b0001,                        // supply below por
    ST_LOAD = 4'b0010,                        // option loading
    ST_HOLD = 4'b0100,                        // release delay
    ST_RUN  = 4'b1000                         // out of reset
  } ssr_state_e;
endpackage : ssr_pkg

// File: verilog/ssr_sync.sv
// ============================================================
// three stage synchroniser with agreement filter
// ============================================================
module ssr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // elaboration check: at least one bit to carry
  if (W < 1) begin : g_bad_w
    $error("ssr_sync: W must be positive");
  end

  logic [W-1:0] s1;         // first stage, read only by s2
  logic [W-1:0] s2;         // second stage
  logic [W-1:0] s3;         // third stage
  logic [W-1:0] next_q;     // filtered next value

  // accept a change once stages two and three agree
  always_comb begin
    next_q = q;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_q[i] = s2[i];
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule : ssr_sync

// File: verilog/ssr_top.sv
// Functional notes
// [RULE_01] enable pin high enables internal supervisor
// [RULE_02] pinless package: supervisor always enabled
// [RULE_03] power-on reset always active from start; code skips it while the enable pin is low
// [RULE_04] after por, load brownout option setting
// [RULE_05] three brownout thresholds selected by option
// [RULE_06] hold reset while below por or brownout
// [RULE_07] detector interrupts on fall, rise or both
// [RULE_08] detector idle until software enables it
// [RULE_09] enable pin low disables internal por/pdr
// [RULE_10] external supervisor then holds reset pin
// [RULE_11] reset asserts at once, releases synchronised
module ssr_top
  import ssr_pkg::*;
#(
  parameter bit HAS_EN_PIN = 1'b1,       // package has enable pin
  parameter int LVL_N      = 8           // detector threshold count
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and analog comparator results
  input  wire logic        supervisor_enable_pin,
  input  wire logic        external_reset_n,
  input  wire logic        supply_above_por,
  input  wire logic [2:0]  supply_above_brownout,
  input  wire logic        supply_above_detector,
  input  wire logic [1:0]  option_brownout,
  // outputs
  output logic [LVL_W-1:0] detector_threshold,
  output logic             detector_enable,
  output logic             system_reset,
  output logic             irq
);
  // elaboration check: threshold count must fit the select field
  if (LVL_N < 1 || LVL_N > (1 << LVL_W)) begin : g_bad_lvl
    $error("ssr_top: LVL_N out of range");
  end

  // ==========================================================
  // input synchronisation
  // ==========================================================
  logic [6:0] raw_in;       // asynchronous inputs bundled
  logic [6:0] syn_in;       // synchronised and filtered
  assign raw_in = {supervisor_enable_pin, external_reset_n,
                   supply_above_por, supply_above_brownout,
                   supply_above_detector};

  ssr_sync #(.W(7)) ssr_sync_i (
    .clk  (clk),
    .srst (srst),
    .d    (raw_in),
    .q    (syn_in)
  );

  logic       en_pin_s;     // synchronised enable pin
  logic       ext_rst_n_s;  // synchronised reset pin
  logic       por_ok;       // supply above por threshold
  logic [2:0] bor_ok;       // supply above each brownout level
  logic       det_above;    // supply above detector threshold
  assign en_pin_s    = syn_in[6];
  assign ext_rst_n_s = syn_in[5];
  assign por_ok      = syn_in[4];
  assign bor_ok      = syn_in[3:1];
  assign det_above   = syn_in[0];

  // supervisor enable: pin on pinned packages, else fixed on
  logic sup_on;
  assign sup_on = HAS_EN_PIN ? en_pin_s : 1'b1; // [RULE_01] [RULE_02]

  // ==========================================================
  // helper: brownout level ok for a given option
  // ==========================================================
  function automatic logic bor_good(input logic [1:0] opt,
                                    input logic [2:0] ok);
    case (opt)
      BOR_L1:  bor_good = ok[0];
      BOR_L2:  bor_good = ok[1];
      BOR_L3:  bor_good = ok[2];
      default: bor_good = 1'b1;          // brownout disabled
    endcase
  endfunction : bor_good

  // ==========================================================
  // reset sequencer
  // ==========================================================
  ssr_state_e       state;
  ssr_state_e       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [1:0]       bor_opt;           // latched option setting
  logic [1:0]       next_bor_opt;
  logic             next_system_reset;
  logic             supply_bad;        // any internal source low

  // internal sources only count while the supervisor is on
  always_comb begin
    supply_bad = sup_on &&                       // [RULE_09]
                 (!por_ok || !bor_good(bor_opt, bor_ok)); // [RULE_06]
  end

  // next state of the sequencer
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bor_opt = bor_opt;
    case (state)
      ST_POR: begin
        next_cnt = '0;
        if (!sup_on || por_ok) begin     // [RULE_03]
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_cnt = cnt + 1'b1;
        if (sup_on && !por_ok) begin
          next_state = ST_POR;
        end else if (cnt == CNT_W'(LOAD_CYC - 1)) begin
          next_bor_opt = option_brownout; // [RULE_04] [RULE_05]
          next_state   = ST_HOLD;
          next_cnt     = '0;
        end
      end
      ST_HOLD: begin
        next_cnt = cnt + 1'b1;
        if (supply_bad || !ext_rst_n_s) begin
          next_cnt = '0;
          if (sup_on && !por_ok) next_state = ST_POR;
        end else if (cnt == CNT_W'(REL_CYC - 1)) begin
          next_state = ST_RUN;            // [RULE_11]
        end
      end
      ST_RUN: begin
        next_cnt = '0;
        if (sup_on && !por_ok) begin
          next_state = ST_POR;
        end else if (supply_bad || !ext_rst_n_s) begin
          next_state = ST_HOLD;           // [RULE_10]
        end
      end
      default: begin
        next_state = ST_POR;
        next_cnt   = '0;
      end
    endcase
    // reset asserts at once on any source, drops only on the step from hold into run
    next_system_reset = !(next_state == ST_RUN) ||
                        supply_bad || !ext_rst_n_s; // [RULE_11]
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state        <= ST_POR;
      cnt          <= '0;
      bor_opt      <= BOR_OFF;
      system_reset <= 1'b1;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      bor_opt      <= next_bor_opt;
      system_reset <= next_system_reset;
    end
  end

  // ==========================================================
  // voltage detector and interrupt
  // ==========================================================
  logic [31:0]     ctrl;
  logic [31:0]     next_ctrl;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] next_ev;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] next_mask;
  logic            det_prev;          // last comparator level
  logic            next_det_prev;
  logic            next_irq;
  logic            det_en;
  logic            wr_acc;            // apb write access
  logic [EV_W-1:0] hit;               // edges seen this cycle

  assign det_en = ctrl[CTRL_EN_BIT];
  assign wr_acc = psel && penable && pwrite;

  // edge detect on the detector output, gated by enable
  always_comb begin
    next_det_prev = det_en ? det_above : 1'b1;  // [RULE_08]
    hit[EV_FALL_BIT] = det_en && det_prev && !det_above &&
                       ctrl[CTRL_FALL_BIT];     // [RULE_07]
    hit[EV_RISE_BIT] = det_en && !det_prev && det_above &&
                       ctrl[CTRL_RISE_BIT];     // [RULE_07]
  end

  // register writes, w1c events with set winning over clear
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_ev   = ev;
    if (wr_acc && paddr == OFF_CTRL) begin
      next_ctrl = pwdata & 32'h0000_0077;
    end
    if (wr_acc && paddr == OFF_MASK) begin
      next_mask = pwdata[EV_W-1:0];
    end
    if (wr_acc && paddr == OFF_IRQ) begin
      next_ev = ev & ~pwdata[EV_W-1:0];
    end
    next_ev  = next_ev | hit;
    next_irq = |(next_ev & next_mask);
  end

  // detector registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl     <= CTRL_RST;
      mask     <= MASK_RST;
      ev       <= '0;
      det_prev <= 1'b1;
      irq      <= 1'b0;
      detector_enable    <= 1'b0;
      detector_threshold <= '0;
    end else begin
      ctrl     <= next_ctrl;
      mask     <= next_mask;
      ev       <= next_ev;
      det_prev <= next_det_prev;
      irq      <= next_irq;
      detector_enable    <= next_ctrl[CTRL_EN_BIT];
      detector_threshold <= next_ctrl[CTRL_LVL_LSB +: LVL_W];
    end
  end

  // ==========================================================
  // apb read path, zero wait states
  // ==========================================================
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        known;

  always_comb begin
    known = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
            (paddr == OFF_IRQ)  || (paddr == OFF_MASK) ||
            (paddr == OFF_OPT);
    next_prdata = '0;
    case (paddr)
      OFF_CTRL:   next_prdata = ctrl;
      OFF_STATUS: next_prdata = {26'h0, sup_on, system_reset,
                                 ext_rst_n_s, por_ok,
                                 bor_good(bor_opt, bor_ok), det_above};
      OFF_IRQ:    next_prdata = {30'h0, ev};
      OFF_MASK:   next_prdata = {30'h0, mask};
      OFF_OPT:    next_prdata = {30'h0, bor_opt};
      default:    next_prdata = '0;    // unmapped reads zero
    endcase
    next_pslverr = psel && !penable && !known;
  end

  // apb output registers: answer in the access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel && !penable) ? next_prdata : '0;
      pready  <= psel && !penable;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_reset_hold;
    @(posedge clk) disable iff (srst)
    (sup_on && !por_ok) |=> system_reset;
  endproperty
  a_reset_hold: assert property (p_reset_hold) // [RULE_06]
    else $error("reset not held below por");

  property p_ext_reset;
    @(posedge clk) disable iff (srst)
    !ext_rst_n_s |=> system_reset;
  endproperty
  a_ext_reset: assert property (p_ext_reset) // [RULE_10]
    else $error("reset pin low but reset released");

  property p_release_sync;
    @(posedge clk) disable iff (srst)
    $fell(system_reset) |-> $past(state) == ST_HOLD;
  endproperty
  a_release_sync: assert property (p_release_sync) // [RULE_11]
    else $error("reset released outside hold");

  property p_det_idle;
    @(posedge clk) disable iff (srst)
    (!det_en && !wr_acc) |=> ev == $past(ev);
  endproperty
  a_det_idle: assert property (p_det_idle) // [RULE_08]
    else $error("detector event while disabled");

  property p_irq_level;
    @(posedge clk) disable iff (srst)
    hit[EV_FALL_BIT] |=> ev[EV_FALL_BIT] &&
                         (!mask[EV_FALL_BIT] || irq);
  endproperty
  a_irq_level: assert property (p_irq_level) // [RULE_07]
    else $error("fall event not latched");

  property p_load_first;
    @(posedge clk) disable iff (srst)
    (state == ST_POR && !(sup_on && !por_ok)) |=> state == ST_LOAD;
  endproperty
  a_load_first: assert property (p_load_first) // [RULE_04]
    else $error("no option load after por");

  property p_pin_off;
    @(posedge clk) disable iff (srst)
    (HAS_EN_PIN && !en_pin_s) |-> !supply_bad;
  endproperty
  a_pin_off: assert property (p_pin_off) // [RULE_09]
    else $error("internal reset active with pin low");

  property p_always_on;
    @(posedge clk) disable iff (srst)
    !HAS_EN_PIN |-> sup_on;
  endproperty
  a_always_on: assert property (p_always_on) // [RULE_02]
    else $error("supervisor off on pinless package");
endmodule : ssr_top

// File: tb/ssr_ext_supervisor.sv
// ====================
// external supply supervisor model
// ====================
module ssr_ext_supervisor #(
  parameter int HOLD = 8                // release delay in cycles
) (
  // clock
  input  wire logic clk,
  // sensed supply, high while above threshold
  input  wire logic supply_ok,
  // reset pin, active low
  output logic      external_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;

  int cnt = 0;                          // cycles left until release

  // reload while the supply is low, then count down after recovery
  always @(posedge clk) begin
    if (!supply_ok) begin
      cnt <= HOLD;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  // pin held low while the supply is low and for the hold time after
  assign external_reset_n = (cnt == 0);
endmodule : ssr_ext_supervisor

// File: tb/ssr_top_bench.sv
// ====================
// supply supervisor reset control bench
// ====================
module ssr_top_bench
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk     = 1'b0;        // 250 mhz clock
  logic        srst    = 1'b1;        // sync reset
  logic        psel    = 1'b0;        // apb request
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        en_pin  = 1'b1;        // supervisor enable pin
  logic        por_ok  = 1'b1;        // comparator levels
  logic [2:0]  bor_ok  = 3'h7;
  logic        det_ok  = 1'b1;
  logic        vdd_ok  = 1'b1;        // supply seen by the model
  logic [1:0]  opt     = BOR_L2;      // option setting
  logic [2:0]  lvl;                   // random detector threshold
  logic [33:0] note;                  // {read, err, data}
  logic [33:0] notes[$];              // expected apb answers
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_rst_n, sys_rst, sys_rst2;
  wire         irq, det_en;
  wire  [2:0]  det_lvl;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  // clock, period 4 ns
  always #2 clk = ~clk;

  // ====================
  // design, partner and a pinless copy
  // ====================
  ssr_top #(.HAS_EN_PIN(1'b1), .LVL_N(8)) ssr_top_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supervisor_enable_pin(en_pin),
    .external_reset_n(ext_rst_n), .supply_above_por(por_ok),
    .supply_above_brownout(bor_ok), .supply_above_detector(det_ok),
    .option_brownout(opt), .detector_threshold(det_lvl),
    .detector_enable(det_en), .system_reset(sys_rst), .irq(irq));

  ssr_top #(.HAS_EN_PIN(1'b0), .LVL_N(8)) ssr_top_nopin_i (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .supervisor_enable_pin(en_pin),
    .external_reset_n(ext_rst_n), .supply_above_por(por_ok),
    .supply_above_brownout(bor_ok), .supply_above_detector(det_ok),
    .option_brownout(opt), .detector_threshold(),
    .detector_enable(), .system_reset(sys_rst2), .irq());

  ssr_ext_supervisor #(.HOLD(8)) ssr_ext_supervisor_i (
    .clk(clk), .supply_ok(vdd_ok), .external_reset_n(ext_rst_n));

  // ====================
  // checking and closing
  // ====================
  // compare one value and count it
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // print counts and verdict, then stop
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // one apb transfer; the expected answer goes on the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    notes.push_back({!wr, err, wr ? 32'h0 : d});
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // wait a bounded time for system reset to reach a level
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (sys_rst !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("system_reset", sys_rst, v);
  endtask : wait_rst

  // monitor: each completed transfer takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      chk("pslverr", pslverr, note[32]);
      if (note[33]) begin
        chk("prdata", prdata, note[31:0]);
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ====================
  // scenarios
  // ====================
  initial begin
    void'($urandom(32'h17a0));
    lvl = 3'($urandom_range(7, 0));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk("system_reset", sys_rst, 1'b1);
    wait_rst(1'b0, 300);
    // one power cycle per option, then lose only the chosen level, or all levels when brownout is off
    for (int k = 0; k < 4; k++) begin
      opt    <= k[1:0];
      por_ok <= 1'b0;
      wait_rst(1'b1, 10);
      por_ok <= 1'b1;
      wait_rst(1'b0, 300);
      apb(1'b0, OFF_OPT, {30'h0, k[1:0]}, 1'b0);
      bor_ok <= (k == 0) ? 3'h0 : ~(3'h1 << (k - 1));
      repeat (12) @(posedge clk);
      chk("system_reset", sys_rst, k != 0);
      bor_ok <= 3'h7;
      wait_rst(1'b0, 300);
    end
    // pin low: comparators ignored, the external supervisor resets
    en_pin <= 1'b0;
    repeat (8) @(posedge clk);
    por_ok <= 1'b0;
    bor_ok <= 3'h0;
    repeat (12) @(posedge clk);
    chk("system_reset", sys_rst, 1'b0);
    chk("pinless system_reset", sys_rst2, 1'b1);
    vdd_ok <= 1'b0;
    wait_rst(1'b1, 20);
    vdd_ok <= 1'b1;
    wait_rst(1'b0, 400);
    // pin high again with the supply still low: internal reset returns
    en_pin <= 1'b1;
    wait_rst(1'b1, 10);
    por_ok <= 1'b1;
    bor_ok <= 3'h7;
    wait_rst(1'b0, 300);
    // detector idle while disabled
    apb(1'b1, OFF_MASK, 32'h3, 1'b0);
    det_ok <= 1'b0;
    repeat (8) @(posedge clk);
    det_ok <= 1'b1;
    repeat (8) @(posedge clk);
    apb(1'b0, OFF_IRQ, 32'h0, 1'b0);
    chk("detector_enable", det_en, 1'b0);
    apb(1'b1, OFF_CTRL, {25'h0, lvl, 4'h7}, 1'b0);
    apb(1'b0, OFF_CTRL, {25'h0, lvl, 4'h7}, 1'b0);
    chk("detector_threshold", det_lvl, lvl);
    chk("detector_enable", det_en, 1'b1);
    // fall then rise, each cleared by writing ones
    for (int k = 0; k < 2; k++) begin
      det_ok <= k[0];
      repeat (8) @(posedge clk);
      chk("irq", irq, 1'b1);
      apb(1'b0, OFF_IRQ, 32'h1 << k, 1'b0);
      apb(1'b1, OFF_IRQ, 32'h3, 1'b0);
      apb(1'b0, OFF_IRQ, 32'h0, 1'b0);
      chk("irq", irq, 1'b0);
    end
    // masked event is recorded but keeps irq low
    apb(1'b1, OFF_MASK, 32'h0, 1'b0);
    det_ok <= 1'b0;
    repeat (8) @(posedge clk);
    chk("irq", irq, 1'b0);
    apb(1'b0, OFF_IRQ, 32'h1, 1'b0);
    // unmapped address is refused
    apb(1'b0, 8'h14, 32'h0, 1'b1);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule : ssr_top_bench
